// File: verilog/pll_divider_registers.sv
// Divider register bank written over the 3-wire serial control port
// Assumes serial pins are asynchronous to sys_clk and far slower than it
//
// Functional notes
// - Select 000 writes the integer register
// - Fractional VCO = 2*fpfd*(int+frac/mod)
// - Mode bit picks integer; fraction then ignored
// - LO frequency is VCO over LO divider
// - Select 001 writes the modulus register
// - Modulus 11 bits DB13..DB3, reset 1536
// - Select 010 writes the fraction register
// - Fraction 11 bits DB13..DB3, reset 768
// - Mode at DB11, integer at DB10..DB3
// - Any divider write starts calibration
// - Writes arrive over 3-wire serial port
`timescale 1ns/1ps
module pll_divider_registers
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // Serial control pins
   input  wire logic        ser_clk,
   input  wire logic        ser_data,
   input  wire logic        ser_le,
   // Divider settings and calibration start
   output logic             divide_mode_select,
   output logic [7:0]       integer_divide_value,
   output logic [10:0]      fraction_modulus,
   output logic [10:0]      fraction_numerator,
   output logic [10:0]      effective_numerator,
   output logic             calibration_start
);
   import pll_divider_pkg::*;

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   // Field layout must fit the word and the output widths
   if (FRAC_MSB >= WORD_BITS || FIELD_LSB != SEL_BITS || MODE_BIT != INT_MSB + 1 ||
       FRAC_MSB - FIELD_LSB + 1 != $bits(fraction_modulus) ||
       INT_MSB - FIELD_LSB + 1 != $bits(integer_divide_value) ||
       int'(BIT_COUNT_LAST) != WORD_BITS - 1) begin : g_layout_check
      $error("divider field layout does not fit the serial word");
   end

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // Reset to pin idle levels, so no false edge follows reset
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic [2:0] sync_prev;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sync_a    <= PIN_IDLE;
         sync_b    <= PIN_IDLE;
         sync_prev <= PIN_IDLE;
      end else begin
         sync_a    <= {ser_le, ser_data, ser_clk};
         sync_b    <= sync_a;
         sync_prev <= sync_b;
      end
   end

   // Edge detectors on the synchronised clock and load enable pins
   logic clk_rise;
   logic le_rise;
   assign clk_rise = sync_b[0] & ~sync_prev[0];
   assign le_rise  = sync_b[2] & ~sync_prev[2];

   // ------------------------------------------------------------
   // Shift register and register bank
   // ------------------------------------------------------------
   function automatic logic sel_is(input logic [WORD_BITS-1:0] w, input logic [2:0] s);
      return w[SEL_BITS-1:0] == s;
   endfunction : sel_is

   logic [WORD_BITS-1:0] shift, next_shift;
   logic [4:0]           bit_count, next_bit_count;
   logic                 word_full, next_word_full;
   logic                 next_mode;
   logic [7:0]           next_int;
   logic [10:0]          next_mod, next_frac, next_eff;
   logic                 next_cal;

   always_comb begin
      next_shift     = shift;
      next_bit_count = bit_count;
      next_word_full = word_full;
      next_mode      = divide_mode_select;
      next_int       = integer_divide_value;
      next_mod       = fraction_modulus;
      next_frac      = fraction_numerator;
      next_cal       = 1'b0;
      // Load enable commits only a complete word
      if (le_rise) begin
         if (word_full) begin
            if (sel_is(shift, SEL_INTEGER)) begin
               next_mode = shift[MODE_BIT];
               next_int  = shift[INT_MSB:FIELD_LSB];
               next_cal  = 1'b1;
            end
            if (sel_is(shift, SEL_MODULUS)) begin
               next_mod = shift[FRAC_MSB:FIELD_LSB];
               next_cal = 1'b1;
            end
            if (sel_is(shift, SEL_FRACTION)) begin
               next_frac = shift[FRAC_MSB:FIELD_LSB];
               next_cal  = 1'b1;
            end
         end
         next_bit_count = 5'h0;
         next_word_full = 1'b0;
      end else if (clk_rise) begin
         // MSB first; count stops at the last bit
         next_shift = {shift[WORD_BITS-2:0], sync_b[1]};
         if (bit_count == BIT_COUNT_LAST)
            next_word_full = 1'b1;
         else
            next_bit_count = bit_count + 5'h1;
      end
      // Integer mode ignores the fraction
      next_eff = next_mode ? 11'h0 : next_frac;
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         shift                <= '0;
         bit_count            <= 5'h0;
         word_full            <= 1'b0;
         divide_mode_select   <= MODE_RESET;
         integer_divide_value <= INTEGER_RESET;
         fraction_modulus     <= MODULUS_RESET;
         fraction_numerator   <= FRACTION_RESET;
         effective_numerator  <= FRACTION_RESET;
         calibration_start    <= 1'b0;
      end else begin
         shift                <= next_shift;
         bit_count            <= next_bit_count;
         word_full            <= next_word_full;
         divide_mode_select   <= next_mode;
         integer_divide_value <= next_int;
         fraction_modulus     <= next_mod;
         fraction_numerator   <= next_frac;
         effective_numerator  <= next_eff;
         calibration_start    <= next_cal;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_cal_on_write: assert property (@(posedge sys_clk) disable iff (!resetn)
      (le_rise && word_full && shift[2:0] <= SEL_FRACTION) |=> calibration_start)
      else $error("calibration not started after divider write");
   chk_cal_only_write: assert property (@(posedge sys_clk) disable iff (!resetn)
      calibration_start |-> $past(le_rise) && $past(word_full))
      else $error("calibration without complete word");
   chk_mod_load: assert property (@(posedge sys_clk) disable iff (!resetn)
      (le_rise && word_full && shift[2:0] == SEL_MODULUS)
      |=> fraction_modulus == $past(shift[13:3]))
      else $error("modulus not loaded");
   chk_frac_load: assert property (@(posedge sys_clk) disable iff (!resetn)
      (le_rise && word_full && shift[2:0] == SEL_FRACTION)
      |=> fraction_numerator == $past(shift[13:3]))
      else $error("fraction not loaded");
   chk_int_load: assert property (@(posedge sys_clk) disable iff (!resetn)
      (le_rise && word_full && shift[2:0] == SEL_INTEGER)
      |=> integer_divide_value == $past(shift[10:3]) && divide_mode_select == $past(shift[11]))
      else $error("integer register not loaded");
   chk_mod_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
      !(le_rise && word_full && shift[2:0] == SEL_MODULUS) |=> $stable(fraction_modulus))
      else $error("modulus changed without its write");
   chk_frac_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
      !(le_rise && word_full && shift[2:0] == SEL_FRACTION) |=> $stable(fraction_numerator))
      else $error("fraction changed without its write");
   chk_int_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
      !(le_rise && word_full && shift[2:0] == SEL_INTEGER) |=> $stable(integer_divide_value))
      else $error("integer changed without its write");
   chk_int_mode: assert property (@(posedge sys_clk) disable iff (!resetn)
      divide_mode_select |-> effective_numerator == 11'h0)
      else $error("fraction used in integer mode");
   chk_frac_mode: assert property (@(posedge sys_clk) disable iff (!resetn)
      !divide_mode_select |-> effective_numerator == fraction_numerator)
      else $error("fraction dropped in fractional mode");
   chk_cal_one_cycle: assert property (@(posedge sys_clk) disable iff (!resetn)
      calibration_start |=> !calibration_start)
      else $error("calibration pulse longer than one cycle");
   chk_mode_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
      !(le_rise && word_full && shift[2:0] == SEL_INTEGER) |=> $stable(divide_mode_select))
      else $error("mode changed without integer write");

   // ------------------------------------------------------------
   // Checks on serial framing
   // ------------------------------------------------------------
   chk_short_drop: assert property (@(posedge sys_clk) disable iff (!resetn)
      (le_rise && !word_full) |=> !calibration_start && $stable(fraction_modulus)
      && $stable(fraction_numerator) && $stable(integer_divide_value))
      else $error("short word was not discarded");
   chk_bad_select: assert property (@(posedge sys_clk) disable iff (!resetn)
      (le_rise && word_full && shift[2:0] > SEL_FRACTION) |=> !calibration_start)
      else $error("calibration on a foreign select");
   chk_full_count: assert property (@(posedge sys_clk) disable iff (!resetn)
      word_full |-> bit_count == BIT_COUNT_LAST)
      else $error("word full before the last bit");
   chk_full_set: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clk_rise && !le_rise && bit_count == BIT_COUNT_LAST) |=> word_full)
      else $error("word not marked full after last bit");
   chk_count_step: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clk_rise && !le_rise && bit_count != BIT_COUNT_LAST)
      |=> bit_count == $past(bit_count) + 5'h1)
      else $error("bit count did not advance");
   chk_count_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
      le_rise |=> bit_count == 5'h0 && !word_full)
      else $error("framing not cleared by load enable");
   chk_shift_in: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clk_rise && !le_rise) |=> shift[0] == $past(sync_b[1]))
      else $error("serial bit not shifted in");
   chk_commit_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
      le_rise |=> $stable(shift))
      else $error("shift register moved on load enable");
endmodule : pll_divider_registers

// File: verilog/pll_divider_pkg.sv
// Package for the divider register bank: offsets, field layout, resets
// Assumes a 24-bit serial word, three select bits in the low positions
package pll_divider_pkg;
   localparam int          WORD_BITS      = 24;
   localparam int          SEL_BITS       = 3;
   localparam int          FIELD_LSB      = 3;
   localparam int          FRAC_MSB       = 13;
   localparam int          INT_MSB        = 10;
   localparam int          MODE_BIT       = 11;
   localparam logic [2:0]  SEL_INTEGER    = 3'h0;
   localparam logic [2:0]  SEL_MODULUS    = 3'h1;
   localparam logic [2:0]  SEL_FRACTION   = 3'h2;
   localparam logic [10:0] MODULUS_RESET  = 11'h600;
   localparam logic [10:0] FRACTION_RESET = 11'h300;
   localparam logic [7:0]  INTEGER_RESET  = 8'h38;
   localparam logic        MODE_RESET     = 1'b0;
   localparam logic [2:0]  PIN_IDLE       = 3'h4;
   localparam logic [4:0]  BIT_COUNT_LAST = 5'h17;
   localparam int          VCO_MULT       = 2;
endpackage : pll_divider_pkg

// File: verification/ser_host.sv
// Serial host model driving the 3-wire control pins
// Assumes go pulses for one sys_clk cycle while done is high
`timescale 1ns/1ps
module ser_host (
   // Bench side
   input  wire logic        sys_clk,
   input  wire logic        go,
   input  wire logic [23:0] word,
   input  wire logic [4:0]  nbits,
   // Serial pins and done handshake
   output logic             ser_clk,
   output logic             ser_data,
   output logic             ser_le,
   output logic             done
);
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      ser_le = 1'b1;
      done = 1'b1;
      forever begin
         @(posedge sys_clk);
         if (go) begin
            done <= 1'b0;
            ser_le <= 1'b0;
            for (int b = nbits - 1; b >= 0; b--) begin
               ser_data <= word[b];
               repeat (4) @(posedge sys_clk);
               ser_clk <= 1'b1;
               repeat (4) @(posedge sys_clk);
               ser_clk <= 1'b0;
            end
            repeat (4) @(posedge sys_clk);
            ser_le <= 1'b1;
            ser_data <= ~ser_data;
            repeat (4) @(posedge sys_clk);
            done <= 1'b1;
         end
      end
   end
endmodule : ser_host

// File: verification/pll_divider_registers_tb_top.sv
// Testbench for the divider register bank
// Assumes ser_host as the far-side serial host
`timescale 1ns/1ps
module pll_divider_registers_tb_top;
   import pll_divider_pkg::*;
   logic        sys_clk = 0, resetn = 0, go = 0, sc, sd, le, done, mode_seen, cs, m;
   logic [23:0] word = 0;
   logic [4:0]  nbits = 5'h18;
   logic [7:0]  iv, i, ivv;
   logic [10:0] fm, fn, en, md, fr, mdv;
   logic [41:0] q[$];
   int          error_cnt = 0, checks = 0, seed = 32'h1974, r;
   wire  [41:0] outs = {mode_seen, iv, fm, fn, en};
   initial forever #50 sys_clk = ~sys_clk;
   pll_divider_registers u_pll_divider_registers (.sys_clk(sys_clk), .resetn(resetn),
      .ser_clk(sc), .ser_data(sd), .ser_le(le), .divide_mode_select(mode_seen),
      .integer_divide_value(iv), .fraction_modulus(fm), .fraction_numerator(fn),
      .effective_numerator(en), .calibration_start(cs));
   ser_host u_ser_host (.sys_clk(sys_clk), .go(go), .word(word), .nbits(nbits),
      .ser_clk(sc), .ser_data(sd), .ser_le(le), .done(done));
   function automatic logic [41:0] st();
      return {m, i, md, fr, m ? 11'h0 : fr};
   endfunction : st
   task automatic cmp(input logic [41:0] a, input logic [41:0] b);
      checks++;
      if (a !== b) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b);
      end
   endtask : cmp
   task automatic end_of_test();
      if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   task automatic wr(input logic [2:0] s, input logic [10:0] v, input logic [4:0] n);
      int k;
      if (n == 5'h18 && s == SEL_INTEGER) {m, i} = v[8:0];
      if (n == 5'h18 && s == SEL_MODULUS) md = v;
      if (n == 5'h18 && s == SEL_FRACTION) fr = v;
      if (n == 5'h18 && s < 3'h3) q.push_back(st());
      @(posedge sys_clk) word <= {10'h0, v, s};
      nbits <= n;
      go <= 1'b1;
      @(posedge sys_clk) go <= 1'b0;
      @(posedge sys_clk);
      for (k = 0; k < 2000 && done !== 1'b1; k++) @(posedge sys_clk);
      if (k == 2000) begin
         error_cnt++;
         end_of_test();
      end
      repeat (10) @(posedge sys_clk);
   endtask : wr
   // Each calibration pulse must match the oldest expected write
   always @(posedge sys_clk) if (resetn && cs === 1'b1) begin
      cmp(outs, q.size() ? q.pop_front() : ~outs);
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      {m, i, md, fr} = {MODE_RESET, INTEGER_RESET, MODULUS_RESET, FRACTION_RESET};
      @(posedge sys_clk) cmp(outs, st());
      for (int j = 0; j < 4; j++) begin
         r = $random(seed);
         mdv = 11'(1 + r[15:4] % 12'h7ff);
         ivv = j[0] ? 8'(21 + r[30:24] % 103) : 8'(24 + r[30:24] % 96);
         wr(SEL_MODULUS, mdv, 5'h18);
         wr(SEL_FRACTION, 11'(r[27:16] % mdv), 5'h18);
         wr(SEL_INTEGER, {2'h0, j[0], ivv}, 5'h18);
      end
      wr(SEL_FRACTION, 11'h155, 5'h14);
      for (int s = 3; s < 8; s++) wr(3'(s), 11'h2aa, 5'h18);
      cmp(outs, st());
      cmp(42'(q.size()), 42'h0);
      end_of_test();
   end
endmodule : pll_divider_registers_tb_top
